// ---- hw/pwmlcf_top.sv ----
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
// How it works
// R01: active width zero keeps the output steadily cleared.
// R02: active width at or above active period keeps the output steadily set.
// R03: period of 65536 clocks tops out at 65535 clocks high.
// R04: counter keeps running during steady 0% or 100% output.
// R05: output enters or leaves the steady levels only at a period boundary.
// R06: software should avoid byte writes to next period and next width.
// R07: 16-bit registers; a 32-bit access acts as two word accesses. Only the pair register does this; period and width ignore the upper half.
// R08: pair write inside a period only updates next registers, output unchanged.
// R09: pair write at period end skips that transfer; transfer one period later.
// R10: completion flag sets whenever a new period begins.
// R11: interrupt request raised at the programmed level while flag is set.
// R12: level zero issues no interrupt request.
// R13: halt-for-debug stops the counter at its held value.
// R14: after halt release counting resumes from the held value.
// R15: output frequency is clock over prescale ratio times counter ratio.
// R16: shortest pulse is one prescaled clock of two or three cycles.
// R17: software computes next period from clock, ratio and wanted frequency.
// R18: software computes next width as duty fraction of the period.
// R19: output set at period start, cleared when counter reaches width.
// R20: counter reloads to one on period match and counts up.
// R21: next registers copy to active at period end or on forced load.
// R22: active period zero gives a 65536 clock period.
module pwmlcf_top
  import pwmlcf_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        freeze_i,
  output logic             pwm_o,
  output logic             irq_req_o,
  output logic      [2:0]  irq_level_o
);

  typedef struct packed {
    logic [1:0]  pre;
    logic [15:0] cnt;
    logic [15:0] per_n;
    logic [15:0] wid_n;
    logic [15:0] per_a;
    logic [15:0] wid_a;
    logic        en;
    logic        div3;
    logic [2:0]  lvl;
    logic        flag;
    logic        armed;
    logic        out;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } pwmlcf_state_s;

  pwmlcf_state_s st_q;
  pwmlcf_state_s st_d;

  logic        tick;
  logic        run_tick;
  logic        match;
  logic        bound;
  logic        xfer;
  logic        en_rise;
  logic        set_ev;
  logic        wr;
  logic        rd;
  logic        pair_wr;
  logic        load_wr;
  logic        mapped;
  logic [15:0] wid_use;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] dat,
                                          input logic [1:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = dat[7:0];
    end
    if (strb[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  always_comb begin
    st_d     = st_q;
    wr       = psel_i && penable_i && st_q.ready && pwrite_i;
    rd       = psel_i && penable_i && st_q.ready && !pwrite_i;
    mapped   = (paddr_i == PWMLCF_CTRL_OFS) || (paddr_i == PWMLCF_PERIOD_OFS) ||
               (paddr_i == PWMLCF_WIDTH_OFS) || (paddr_i == PWMLCF_PAIR_OFS) ||
               (paddr_i == PWMLCF_COUNT_OFS);
    // prescaled clock enable, one cycle in two or three
    tick     = st_q.pre == (st_q.div3 ? PWMLCF_PRE_MAX3 : PWMLCF_PRE_MAX2); // R15 R16
    st_d.pre = tick ? PWMLCF_PRE_RST : st_q.pre + 2'h1;
    run_tick = st_q.en && !freeze_i && tick; // R13
    match    = st_q.cnt == st_q.per_a; // R22
    bound    = run_tick && match;
    pair_wr  = wr && (paddr_i == PWMLCF_PAIR_OFS) && (pstrb_i == PWMLCF_STRB_ALL);
    load_wr  = wr && (paddr_i == PWMLCF_CTRL_OFS) && pstrb_i[0] &&
               pwdata_i[PWMLCF_LOAD_BIT];
    en_rise  = wr && (paddr_i == PWMLCF_CTRL_OFS) && pstrb_i[0] &&
               pwdata_i[PWMLCF_EN_BIT] && !st_q.en;
    xfer     = (bound && !pair_wr) || load_wr || en_rise; // R09 R21
    set_ev   = bound || en_rise;
    wid_use  = xfer ? st_q.wid_n : st_q.wid_a;

    // apb answer: data and ready registered in the setup cycle
    st_d.ready = psel_i && !penable_i;
    st_d.err   = psel_i && !penable_i && !mapped;
    if (psel_i && !penable_i) begin
      case (paddr_i)
        PWMLCF_CTRL_OFS: begin
          st_d.rdata = PWMLCF_DATA_RST;
          st_d.rdata[PWMLCF_EN_BIT]                  = st_q.en;
          st_d.rdata[PWMLCF_DIV3_BIT]                = st_q.div3;
          st_d.rdata[PWMLCF_LVL_LSB +: 3]            = st_q.lvl;
          st_d.rdata[PWMLCF_FLAG_BIT]                = st_q.flag;
        end
        PWMLCF_PERIOD_OFS: st_d.rdata = {16'h0000, st_q.per_n};
        PWMLCF_WIDTH_OFS:  st_d.rdata = {16'h0000, st_q.wid_n};
        PWMLCF_PAIR_OFS:   st_d.rdata = {st_q.wid_n, st_q.per_n};
        PWMLCF_COUNT_OFS:  st_d.rdata = {16'h0000, st_q.cnt};
        default:           st_d.rdata = PWMLCF_DATA_RST;
      endcase
    end

    // register writes; upper half of single registers is ignored
    if (wr) begin
      case (paddr_i)
        PWMLCF_CTRL_OFS: begin
          if (pstrb_i[0]) begin
            st_d.en   = pwdata_i[PWMLCF_EN_BIT];
            st_d.div3 = pwdata_i[PWMLCF_DIV3_BIT];
            st_d.lvl  = pwdata_i[PWMLCF_LVL_LSB +: 3];
          end
        end
        PWMLCF_PERIOD_OFS: st_d.per_n = merge16(st_q.per_n, pwdata_i[15:0], pstrb_i[1:0]); // R07
        PWMLCF_WIDTH_OFS:  st_d.wid_n = merge16(st_q.wid_n, pwdata_i[15:0], pstrb_i[1:0]); // R07
        PWMLCF_PAIR_OFS: begin
          st_d.per_n = merge16(st_q.per_n, pwdata_i[15:0], pstrb_i[1:0]); // R08
          st_d.wid_n = merge16(st_q.wid_n, pwdata_i[31:16], pstrb_i[3:2]); // R08
        end
        default: begin
        end
      endcase
    end

    // active registers take whole words only
    if (xfer) begin
      st_d.per_a = st_q.per_n; // R21
      st_d.wid_a = st_q.wid_n; // R21
    end

    // counter and output sequencer
    if (!st_q.en) begin
      st_d.cnt = PWMLCF_CNT_RST;
      st_d.out = 1'b0;
    end
    if (en_rise) begin
      st_d.cnt = PWMLCF_CNT_RST;
      st_d.out = wid_use != PWMLCF_REG_RST; // R01 R19
    end else if (bound) begin
      st_d.cnt = PWMLCF_CNT_RST; // R20
      st_d.out = wid_use != PWMLCF_REG_RST; // R01 R02 R05 R19
    end else if (run_tick) begin
      st_d.cnt = st_q.cnt + 16'h0001; // R04 R14
      if (st_q.cnt == st_q.wid_a) begin
        st_d.out = 1'b0; // R03 R19
      end
    end
    if (wr && (paddr_i == PWMLCF_CTRL_OFS) && pstrb_i[0] && !pwdata_i[PWMLCF_EN_BIT]) begin
      st_d.out = 1'b0;
    end

    // flag: read as one then write zero clears; a set in between wins
    if (rd && (paddr_i == PWMLCF_CTRL_OFS) && st_q.flag) begin
      st_d.armed = 1'b1;
    end
    if (wr && (paddr_i == PWMLCF_CTRL_OFS) && pstrb_i[1]) begin
      if (!pwdata_i[PWMLCF_FLAG_BIT] && st_q.armed) begin
        st_d.flag = 1'b0;
      end
      st_d.armed = 1'b0;
    end
    if (set_ev) begin
      st_d.flag  = 1'b1; // R10
      st_d.armed = 1'b0;
    end
    if (!st_d.en) begin
      st_d.flag  = 1'b0;
      st_d.armed = 1'b0;
    end
    st_d.irq = st_d.flag && (st_d.lvl != PWMLCF_LVL_RST); // R11 R12
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q.pre   <= PWMLCF_PRE_RST;
      st_q.cnt   <= PWMLCF_CNT_RST;
      st_q.per_n <= PWMLCF_REG_RST;
      st_q.wid_n <= PWMLCF_REG_RST;
      st_q.per_a <= PWMLCF_REG_RST;
      st_q.wid_a <= PWMLCF_REG_RST;
      st_q.en    <= 1'b0;
      st_q.div3  <= 1'b0;
      st_q.lvl   <= PWMLCF_LVL_RST;
      st_q.flag  <= 1'b0;
      st_q.armed <= 1'b0;
      st_q.out   <= 1'b0;
      st_q.irq   <= 1'b0;
      st_q.rdata <= PWMLCF_DATA_RST;
      st_q.ready <= 1'b0;
      st_q.err   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_o    = st_q.rdata;
  assign pready_o    = st_q.ready;
  assign pslverr_o   = st_q.err;
  assign pwm_o       = st_q.out;
  assign irq_req_o   = st_q.irq;
  assign irq_level_o = st_q.lvl;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  zero_width_a: assert property ((bound && wid_use == 16'h0000) |=> !pwm_o) // R01
    else $error("output not cleared for zero width");
  full_width_a: assert property ((bound && st_q.wid_n >= st_q.per_n && st_q.per_n != 16'h0000
                                  && !pair_wr) |=> pwm_o || !st_q.en) // R02
    else $error("output not set for full width");
  max_duty_a: assert property ((run_tick && st_q.per_a == 16'h0000 && st_q.wid_a == 16'hFFFF
                                && st_q.cnt == 16'hFFFF) |=> !pwm_o) // R03
    else $error("output not cleared at end of longest pulse");
  count_run_a: assert property ((run_tick && !match) |=> st_q.cnt == $past(st_q.cnt) + 16'h0001) // R04
    else $error("counter did not advance");
  edge_bound_a: assert property ((st_q.en && $past(st_q.en) && $changed(pwm_o) && !$past(en_rise))
                                 |-> $past(run_tick) || $past(wr)) // R05
    else $error("output changed off a counter step");
  // a width compare may still clear the output in the same step as the pair write
  pair_hold_a: assert property ((pair_wr && !bound && !load_wr && !en_rise)
                                |=> st_q.per_a == $past(st_q.per_a) &&
                                    ($stable(pwm_o) || $past(run_tick))) // R08
    else $error("pair write disturbed active period");
  pair_skip_a: assert property ((pair_wr && bound) |=> st_q.wid_a == $past(st_q.wid_a)) // R09
    else $error("pair write at boundary transferred");
  flag_set_a: assert property ((bound && st_q.en) |=> st_q.flag || !st_q.en) // R10
    else $error("flag not set at period start");
  irq_lvl_a: assert property ((irq_level_o == 3'h0) |-> !irq_req_o) // R11 R12
    else $error("request raised at level zero");
  freeze_a: assert property ((st_q.en && freeze_i && !en_rise) |=> $stable(st_q.cnt) || !st_q.en) // R13
    else $error("counter moved during freeze");
  tick_space_a: assert property (tick |=> !tick) // R15 R16
    else $error("prescaled clock faster than half rate");
  reload_a: assert property ((bound && !en_rise) |=> st_q.cnt == 16'h0001) // R20
    else $error("counter not reloaded to one");
  force_load_a: assert property (load_wr |=> st_q.per_a == $past(st_q.per_n)) // R21
    else $error("forced load did not transfer");

  // bus answer
  ready_setup_a: assert property ((psel_i && !penable_i) |=> pready_o) // R07
    else $error("no ready after setup cycle");

  ready_pulse_a: assert property (pready_o |=> !pready_o) // R07
    else $error("ready held longer than one cycle");

  err_unmapped_a: assert property ((psel_i && !penable_i && !mapped) |=> pslverr_o) // R07
    else $error("unmapped access not refused");

  err_mapped_a: assert property ((psel_i && !penable_i && mapped) |=> !pslverr_o) // R07
    else $error("mapped access refused");

  err_ready_a: assert property (pslverr_o |-> pready_o) // R07
    else $error("error without ready");

  half_zero_a: assert property ((psel_i && !penable_i && paddr_i == PWMLCF_PERIOD_OFS)
                                |=> prdata_o[31:16] == 16'h0000) // R07
    else $error("upper half of period read not zero");

  // next registers
  per_write_a: assert property ((wr && paddr_i == PWMLCF_PERIOD_OFS && pstrb_i[1:0] == 2'h3)
                                |=> st_q.per_n == $past(pwdata_i[15:0])) // R07
    else $error("word write to next period lost");

  wid_write_a: assert property ((wr && paddr_i == PWMLCF_WIDTH_OFS && pstrb_i[1:0] == 2'h3)
                                |=> st_q.wid_n == $past(pwdata_i[15:0])) // R07
    else $error("word write to next width lost");

  pair_store_a: assert property (pair_wr |=> st_q.per_n == $past(pwdata_i[15:0]) &&
                                             st_q.wid_n == $past(pwdata_i[31:16])) // R08
    else $error("pair write not stored");

  // transfers into the active registers
  bound_xfer_a: assert property ((bound && !pair_wr) |=> st_q.per_a == $past(st_q.per_n) &&
                                                      st_q.wid_a == $past(st_q.wid_n)) // R21
    else $error("no transfer at period end");

  skip_period_a: assert property ((pair_wr && bound) |=> st_q.per_a == $past(st_q.per_a)) // R09
    else $error("period transferred despite pair write");

  load_width_a: assert property (load_wr |=> st_q.wid_a == $past(st_q.wid_n)) // R21
    else $error("forced load did not transfer width");

  // output sequencer
  width_clear_a: assert property ((run_tick && !match && st_q.cnt == st_q.wid_a) |=> !pwm_o) // R19
    else $error("output not cleared at width match");

  period_set_a: assert property ((bound && !pair_wr && st_q.wid_n != 16'h0000)
                                 |=> pwm_o || !st_q.en) // R19
    else $error("output not set at period start");

  steady_low_a: assert property ((st_q.en && st_q.wid_a == 16'h0000 && !xfer && !pwm_o)
                                 |=> !pwm_o) // R01
    else $error("glitch on steady low output");

  // a forced load may leave the counter above the new period, hence the range guard
  steady_high_a: assert property ((st_q.en && st_q.per_a != 16'h0000 && pwm_o && !xfer && !wr &&
                                   st_q.wid_a >= st_q.per_a && st_q.cnt <= st_q.per_a)
                                  |=> pwm_o) // R02
    else $error("glitch on steady high output");

  enable_a: assert property (en_rise |=> pwm_o == ($past(st_q.wid_n) != 16'h0000) && st_q.flag) // R10
    else $error("enable did not start a period");

  // counter
  count_stall_a: assert property ((!tick && st_q.en && !en_rise) |=> $stable(st_q.cnt)) // R15
    else $error("counter moved between prescaled ticks");

  long_period_a: assert property ((run_tick && st_q.per_a == 16'h0000 && st_q.cnt == 16'hFFFF)
                                  |=> st_q.cnt == 16'h0000) // R22
    else $error("counter did not roll over for longest period");

  freeze_hold_a: assert property ((freeze_i && st_q.en) |-> !run_tick) // R13
    else $error("counter step during freeze");

  resume_a: assert property (($past(freeze_i) && !freeze_i && run_tick && !match)
                             |=> st_q.cnt == $past(st_q.cnt) + 16'h0001) // R14
    else $error("counter did not resume from held value");

  div3_gap_a: assert property ((tick && st_q.div3) |=> !tick ##1 (!tick || !st_q.div3)) // R16
    else $error("divide by three tick too early");

  // flag and request
  flag_keep_a: assert property ((st_q.flag && !(wr && paddr_i == PWMLCF_CTRL_OFS && pstrb_i[1]))
                                |=> st_q.flag || !st_q.en) // R10
    else $error("flag dropped without software clear");

  irq_follow_a: assert property ((st_q.flag && st_q.lvl != 3'h0) |-> irq_req_o) // R11
    else $error("request missing while flag set");

  irq_clear_a: assert property (!st_q.flag |-> !irq_req_o) // R11
    else $error("request without flag");

endmodule

// ---- hw/pwmlcf_pkg.sv ----
package pwmlcf_pkg;

  // register byte offsets
  localparam logic [11:0] PWMLCF_CTRL_OFS   = 12'h000;
  localparam logic [11:0] PWMLCF_PERIOD_OFS = 12'h004;
  localparam logic [11:0] PWMLCF_WIDTH_OFS  = 12'h008;
  localparam logic [11:0] PWMLCF_PAIR_OFS   = 12'h00C;
  localparam logic [11:0] PWMLCF_COUNT_OFS  = 12'h010;

  // control/status field positions
  localparam int PWMLCF_EN_BIT    = 0;
  localparam int PWMLCF_DIV3_BIT  = 1;
  localparam int PWMLCF_LOAD_BIT  = 2;
  localparam int PWMLCF_LVL_LSB   = 4;
  localparam int PWMLCF_FLAG_BIT  = 15;

  // reset values
  localparam logic [15:0] PWMLCF_CNT_RST   = 16'h0001;
  localparam logic [15:0] PWMLCF_REG_RST   = 16'h0000;
  localparam logic [2:0]  PWMLCF_LVL_RST   = 3'h0;
  localparam logic [31:0] PWMLCF_DATA_RST  = 32'h0000_0000;

  // prescaled clock: system clock divided by 2 or 3
  localparam int          PWMLCF_DIV_LO    = 2;
  localparam int          PWMLCF_DIV_HI    = 3;
  localparam logic [1:0]  PWMLCF_PRE_MAX2  = 2'(PWMLCF_DIV_LO - 1);
  localparam logic [1:0]  PWMLCF_PRE_MAX3  = 2'(PWMLCF_DIV_HI - 1);
  localparam logic [1:0]  PWMLCF_PRE_RST   = 2'h0;

  localparam logic [15:0] PWMLCF_CNT_TOP   = 16'hFFFF;
  localparam logic [3:0]  PWMLCF_STRB_ALL  = 4'hF;

endpackage

// ---- sim/pwmlcf_load_model.sv ----
`timescale 1ns/1ns
// load on the output pin: measures last period and last high time in clocks
module pwmlcf_load_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        pwm_i,
  output logic      [31:0] period_o,
  output logic      [31:0] high_o
);
  logic [31:0] cnt_q;
  logic        prev_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q    <= 32'h0;
      prev_q   <= 1'b0;
      period_o <= 32'h0;
      high_o   <= 32'h0;
    end else begin
      prev_q <= pwm_i;
      cnt_q  <= cnt_q + 32'h1;
      if (pwm_i && !prev_q) begin
        period_o <= cnt_q;
        cnt_q    <= 32'h1;
      end
      if (!pwm_i && prev_q) begin
        high_o <= cnt_q;
      end
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb
  import pwmlcf_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, freeze = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, per, hi, r, c1, c2;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, pwm, irq_req, err;
  logic [2:0]  irq_level;
  int          failures = 0, compares = 0;
  pwmlcf_top DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .freeze_i(freeze),
    .pwm_o(pwm), .irq_req_o(irq_req), .irq_level_o(irq_level));
  pwmlcf_load_model load (.clk_i(clk), .rst_n_i(rst_n), .pwm_i(pwm), .period_o(per),
    .high_o(hi));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // word writes only; no byte writes to next period or width
  task automatic cfg(input logic [15:0] p, input logic [15:0] w, input logic [31:0] c);
    apb(1'b1, PWMLCF_CTRL_OFS, 32'h0, PWMLCF_STRB_ALL);
    apb(1'b1, PWMLCF_PAIR_OFS, {w, p}, PWMLCF_STRB_ALL);
    apb(1'b1, PWMLCF_CTRL_OFS, c, PWMLCF_STRB_ALL);
  endtask
  task automatic ones(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      k += int'(pwm);
    end
  endtask
  task automatic t_shape();
    logic [15:0] tp[3] = '{16'h5, 16'h5, 16'h2};
    logic [15:0] tw[3] = '{16'h2, 16'h2, 16'h1};
    int          k;
    for (int i = 0; i < 3; i++) begin
      k = (i == 1) ? PWMLCF_DIV_HI : PWMLCF_DIV_LO;
      cfg(tp[i], tw[i], 32'h1 | (32'(i == 1) << PWMLCF_DIV3_BIT));
      repeat (int'(tp[i]) * k * 3) @(posedge clk);
      chk(per, 32'(tp[i]) * 32'(k));
      chk(hi, 32'(tw[i]) * 32'(k));
    end
    $display("test shape done");
  endtask
  task automatic t_limits();
    logic [15:0] tw[3] = '{16'h0, 16'h6, 16'h9};
    int          k;
    for (int i = 0; i < 3; i++) begin
      cfg(16'h6, tw[i], 32'h1);
      repeat (24) @(posedge clk);
      ones(36, k);
      chk(32'(k), (i == 0) ? 32'd0 : 32'd36);
    end
    apb(1'b0, PWMLCF_COUNT_OFS, 32'h0, 4'h0);
    c1 = r;
    repeat (3) @(posedge clk);
    apb(1'b0, PWMLCF_COUNT_OFS, 32'h0, 4'h0);
    chk(32'(r !== c1), 32'h1);
    $display("test limits done");
  endtask
  task automatic t_irq();
    for (int l = 0; l < 8; l++) begin
      apb(1'b1, PWMLCF_CTRL_OFS, 32'h1 | (32'(l) << PWMLCF_LVL_LSB), PWMLCF_STRB_ALL);
      repeat (2) @(posedge clk);
      chk(32'(irq_level), 32'(l));
      chk(32'(irq_req), 32'(l != 0));
    end
    apb(1'b0, PWMLCF_CTRL_OFS, 32'h0, 4'h0);
    chk(32'(r[PWMLCF_FLAG_BIT]), 32'h1);
    $display("test irq done");
  endtask
  task automatic t_freeze();
    cfg(16'd200, 16'd100, 32'h1);
    repeat (20) @(posedge clk);
    freeze <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, PWMLCF_COUNT_OFS, 32'h0, 4'h0);
    c1 = r;
    repeat (20) @(posedge clk);
    apb(1'b0, PWMLCF_COUNT_OFS, 32'h0, 4'h0);
    chk(r, c1);
    freeze <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, PWMLCF_COUNT_OFS, 32'h0, 4'h0);
    chk(32'(r > c1 && r <= c1 + 32'h3), 32'h1);
    $display("test freeze done");
  endtask
  task automatic t_bus();
    apb(1'b1, PWMLCF_PAIR_OFS, 32'h0007_0009, PWMLCF_STRB_ALL);
    apb(1'b0, PWMLCF_PERIOD_OFS, 32'h0, 4'h0);
    chk(r, 32'h9);
    apb(1'b0, PWMLCF_WIDTH_OFS, 32'h0, 4'h0);
    chk(r, 32'h7);
    apb(1'b0, 12'hFFC, 32'h0, 4'h0);
    chk({r[30:0], err}, 32'h1);
    $display("test bus done");
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_shape();
    t_limits();
    t_irq();
    t_freeze();
    t_bus();
    finish_test();
  end
endmodule
